// File: rtl/sdh_config_status.sv
// Card host configuration, status and time-out logic
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "sdh_regs.svh"
module sdh_config_status import sdh_pkg::*; (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [5:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [31:0] i_rx_data,
  input  wire logic [7:0]  i_fifo_level,
  input  wire logic        i_cmd_sent,
  input  wire logic        i_rsp_rcvd,
  input  wire logic        i_rsp_crc_err,
  input  wire logic        i_rd_crc_err,
  input  wire logic        i_wr_crc_err,
  input  wire logic        i_byte_moved,
  input  wire logic        i_stop_sent,
  input  wire logic        i_data_complete,
  input  wire logic        i_card_busy,
  output logic             o_card_clk,
  output logic             o_cmd_logic_rst,
  output logic             o_data_logic_rst,
  output logic             o_bus_4bit,
  output logic             o_cmd_start,
  output logic             o_irq
);
  logic        rst_s1_r;
  logic        rst_n_r;
  logic        busy_s1_r;
  logic        busy_r;
  logic [2:0]  ctl_r;
  logic [7:0]  div_r;
  logic        card_clock_output_enable_r;
  logic [12:0] mask_r;
  logic [7:0]  tor_r;
  logic [15:0] tod_r;
  logic [11:0] blen_r;
  logic [15:0] nblk_r;
  logic [15:0] nblc_r;
  logic [7:0]  thr_r;
  logic [3:0]  cmd_r;
  logic [12:0] st0_r;
  logic [12:0] st0_set;
  logic [7:0]  divcnt_r;
  logic        mclk_r;
  logic        tick;
  logic        run;
  logic [7:0]  rsp_cnt_r;
  logic [15:0] dat_cnt_r;
  logic [11:0] byte_cnt_r;
  logic        rx_above_r;
  logic        tx_below_r;
  logic        rx_above;
  logic        tx_below;
  logic        cmd_wr;
  logic        final_byte;
  sdh_cmd_st_t cst_r;
  sdh_dat_st_t dst_r;

  // Reset release
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Busy pin synchroniser
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      busy_s1_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      busy_s1_r <= i_card_busy;
      busy_r    <= busy_s1_r;
    end
  end

  assign cmd_wr = i_wr && (i_addr == `SDH_OFS_CMD) && !ctl_r[`SDH_CTL_CRST];

  // Configuration registers
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctl_r   <= `SDH_CTL_RST;
      div_r   <= `SDH_DIV_RST;
      card_clock_output_enable_r <= 1'b0;
      mask_r  <= 13'h0000;
      tor_r   <= 8'h00;
      tod_r   <= 16'h0000;
      blen_r  <= `SDH_BLEN_RST;
      nblk_r  <= 16'h0000;
      thr_r   <= 8'h00;
      cmd_r   <= 4'h0;
    end else if (i_wr) begin
      case (i_addr)
        `SDH_OFS_CTL:  ctl_r   <= i_wdata[2:0];
        `SDH_OFS_CLK: begin
          div_r   <= i_wdata[7:0];
          card_clock_output_enable_r <= i_wdata[`SDH_CLK_EN];
        end
        `SDH_OFS_IM:   mask_r  <= i_wdata[12:0];
        `SDH_OFS_TOR:  tor_r   <= i_wdata[7:0];
        `SDH_OFS_TOD:  tod_r   <= i_wdata[15:0];
        `SDH_OFS_BLEN: blen_r  <= i_wdata[11:0];
        `SDH_OFS_NBLK: nblk_r  <= i_wdata[15:0];
        `SDH_OFS_FIFO: thr_r   <= i_wdata[7:0];
        `SDH_OFS_CMD: begin
          if (!ctl_r[`SDH_CTL_CRST]) begin
            cmd_r <= i_wdata[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Memory clock divider
  assign run  = card_clock_output_enable_r || (cst_r != CMD_IDLE) || (dst_r != DAT_IDLE); // R4
  assign tick = run && (divcnt_r >= div_r) && !mclk_r;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      divcnt_r <= 8'h00;
      mclk_r   <= 1'b0;
    end else if (!run) begin
      divcnt_r <= 8'h00;
      mclk_r   <= 1'b0; // R4
    end else if (divcnt_r >= div_r) begin
      divcnt_r <= 8'h00;
      mclk_r   <= !mclk_r; // R3
    end else begin
      divcnt_r <= divcnt_r + 8'h01; // R3
    end
  end

  // Command sequence
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cst_r     <= CMD_IDLE;
      rsp_cnt_r <= 8'h00;
    end else if (ctl_r[`SDH_CTL_CRST]) begin
      cst_r     <= CMD_IDLE; // R1
      rsp_cnt_r <= 8'h00;
    end else begin
      case (cst_r)
        CMD_IDLE: begin
          if (cmd_wr) begin
            cst_r <= CMD_SEND;
          end
        end
        CMD_SEND: begin
          rsp_cnt_r <= 8'h00;
          if (i_cmd_sent) begin
            if (cmd_r[`SDH_CMD_RSP]) begin
              cst_r <= CMD_RSP;
            end else if (cmd_r[`SDH_CMD_BSY]) begin
              cst_r <= CMD_BSY;
            end else begin
              cst_r <= CMD_IDLE;
            end
          end
        end
        CMD_RSP: begin
          if (i_rsp_rcvd) begin
            rsp_cnt_r <= 8'h00;
            cst_r <= cmd_r[`SDH_CMD_BSY] ? CMD_BSY : CMD_IDLE;
          end else if (tor_r != 8'h00 && tick) begin
            rsp_cnt_r <= rsp_cnt_r + 8'h01;
            if (rsp_cnt_r + 8'h01 == tor_r) begin
              cst_r <= CMD_IDLE; // R8
            end
          end
        end
        CMD_BSY: begin
          // Wait out busy synchroniser latency
          if (rsp_cnt_r != `SDH_BSY_SETTLE) begin
            rsp_cnt_r <= rsp_cnt_r + 8'h01;
          end else if (!busy_r) begin
            cst_r <= CMD_IDLE; // R16
          end
        end
        default: cst_r <= CMD_IDLE;
      endcase
    end
  end

  assign final_byte = i_byte_moved && (byte_cnt_r + 12'h001 == blen_r) &&
                      (nblc_r == 16'h0001) && (nblk_r != 16'h0000);

  // Data sequence and block counting
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dst_r      <= DAT_IDLE;
      dat_cnt_r  <= 16'h0000;
      byte_cnt_r <= 12'h000;
      nblc_r     <= 16'h0000;
    end else if (ctl_r[`SDH_CTL_DRST]) begin
      dst_r      <= DAT_IDLE; // R1
      dat_cnt_r  <= 16'h0000;
      byte_cnt_r <= 12'h000;
      nblc_r     <= 16'h0000;
    end else begin
      case (dst_r)
        DAT_IDLE: begin
          dat_cnt_r  <= 16'h0000;
          byte_cnt_r <= 12'h000;
          if (cmd_wr && i_wdata[`SDH_CMD_DAT]) begin
            nblc_r <= nblk_r;
            dst_r  <= i_wdata[`SDH_CMD_WR] ? DAT_XFER : DAT_WAIT;
          end
        end
        DAT_WAIT: begin
          if (i_byte_moved) begin
            dst_r <= DAT_XFER;
          end else if (tod_r != 16'h0000 && tick) begin
            dat_cnt_r <= dat_cnt_r + 16'h0001;
            if (dat_cnt_r + 16'h0001 == tod_r) begin
              dst_r <= DAT_IDLE; // R9
            end
          end
        end
        default: ;
      endcase
      if (dst_r == DAT_XFER || (dst_r == DAT_WAIT && i_byte_moved)) begin
        if (i_stop_sent) begin
          dst_r <= DAT_FIN; // R11
        end else if (final_byte) begin
          dst_r <= DAT_FIN; // R11
        end else if (i_byte_moved) begin
          if (byte_cnt_r + 12'h001 == blen_r) begin
            byte_cnt_r <= 12'h000;
            if (nblk_r != 16'h0000) begin
              nblc_r <= nblc_r - 16'h0001; // R11
            end
          end else begin
            byte_cnt_r <= byte_cnt_r + 12'h001;
          end
        end
      end
      if (dst_r == DAT_FIN && i_data_complete) begin
        dst_r <= DAT_IDLE; // R18
      end
      if (!(dst_r inside {DAT_IDLE, DAT_WAIT, DAT_XFER, DAT_FIN})) begin
        dst_r <= DAT_IDLE;
      end
    end
  end

  // FIFO threshold crossings
  assign rx_above = i_fifo_level > thr_r;
  assign tx_below = i_fifo_level < thr_r;
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_above_r <= 1'b0;
      tx_below_r <= 1'b0;
    end else begin
      rx_above_r <= rx_above;
      tx_below_r <= tx_below;
    end
  end

  // Status event sources
  always_comb begin
    st0_set = 13'h0000;
    st0_set[`SDH_ST_DATDN] = dst_r == DAT_FIN && i_data_complete; // R18
    st0_set[`SDH_ST_BSYDN] = cst_r == CMD_BSY && !busy_r &&
                             rsp_cnt_r == `SDH_BSY_SETTLE; // R16
    st0_set[`SDH_ST_RSPDN] = (cst_r == CMD_RSP && i_rsp_rcvd &&
                              !i_rsp_crc_err) ||
                             (cst_r == CMD_SEND && i_cmd_sent &&
                              !cmd_r[`SDH_CMD_RSP]); // R15
    st0_set[`SDH_ST_TORD]  = dst_r == DAT_WAIT && !i_byte_moved &&
                             tod_r != 16'h0000 && tick &&
                             dat_cnt_r + 16'h0001 == tod_r; // R9
    st0_set[`SDH_ST_TORS]  = cst_r == CMD_RSP && !i_rsp_rcvd &&
                             tor_r != 8'h00 && tick &&
                             rsp_cnt_r + 8'h01 == tor_r; // R8
    st0_set[`SDH_ST_WRITE_CRC_ERROR_FLAG] = i_wr_crc_err; // R14
    st0_set[`SDH_ST_READ_CRC_ERROR_FLAG] = i_rd_crc_err; // R14
    st0_set[`SDH_ST_RESPONSE_CRC_ERROR_FLAG] = cst_r == CMD_RSP && i_rsp_rcvd &&
                             i_rsp_crc_err; // R14
    st0_set[`SDH_ST_TXRDY] = tx_below && !tx_below_r; // R13
    st0_set[`SDH_ST_RXRDY] = rx_above && !rx_above_r; // R12
    st0_set[`SDH_ST_TRNDN] = (dst_r inside {DAT_WAIT, DAT_XFER}) &&
                             final_byte && !i_stop_sent; // R19
  end

  // Primary status flags, set wins over clear
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st0_r <= 13'h0000;
    end else if (i_rd && i_addr == `SDH_OFS_ST0) begin
      st0_r <= st0_set; // R22
    end else if (i_rd && i_addr == `SDH_OFS_DRR) begin
      st0_r <= (st0_r & ~(13'h0001 << `SDH_ST_RXRDY)) | st0_set; // R12
    end else begin
      st0_r <= st0_r | st0_set;
    end
  end

  // Interrupt request
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(st0_r & mask_r); // R7 R21
    end
  end

  // Register reads, data one cycle after strobe
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `SDH_OFS_CTL:  o_rdata <= {29'h0, ctl_r};
        `SDH_OFS_CLK:  o_rdata <= {23'h0, card_clock_output_enable_r, div_r};
        `SDH_OFS_ST0:  o_rdata <= {19'h0, st0_r};
        `SDH_OFS_ST1:  o_rdata <= {30'h0, !run, busy_r}; // R17
        `SDH_OFS_IM:   o_rdata <= {19'h0, mask_r};
        `SDH_OFS_TOR:  o_rdata <= {24'h0, tor_r};
        `SDH_OFS_TOD:  o_rdata <= {16'h0, tod_r};
        `SDH_OFS_BLEN: o_rdata <= {20'h0, blen_r};
        `SDH_OFS_NBLK: o_rdata <= {16'h0, nblk_r};
        `SDH_OFS_NBLC: o_rdata <= {16'h0, nblc_r};
        `SDH_OFS_DRR:  o_rdata <= i_rx_data;
        `SDH_OFS_CMD:  o_rdata <= {28'h0, cmd_r};
        `SDH_OFS_FIFO: o_rdata <= {24'h0, thr_r};
        default:       o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_card_clk       <= 1'b0;
      o_cmd_logic_rst  <= 1'b1;
      o_data_logic_rst <= 1'b1;
      o_bus_4bit       <= 1'b0;
      o_cmd_start      <= 1'b0;
    end else begin
      o_card_clk       <= mclk_r; // R4
      o_cmd_logic_rst  <= ctl_r[`SDH_CTL_CRST]; // R1
      o_data_logic_rst <= ctl_r[`SDH_CTL_DRST]; // R1
      o_bus_4bit       <= ctl_r[`SDH_CTL_WIDTH]; // R6
      o_cmd_start      <= cmd_wr;
    end
  end
endmodule : sdh_config_status

// File: rtl/sdh_pkg.sv
// Types for the card host configuration and status block
package sdh_pkg;
  typedef enum logic [3:0] {
    CMD_IDLE = 4'h1,
    CMD_SEND = 4'h2,
    CMD_RSP  = 4'h4,
    CMD_BSY  = 4'h8
  } sdh_cmd_st_t;
  typedef enum logic [3:0] {
    DAT_IDLE = 4'h1,
    DAT_WAIT = 4'h2,
    DAT_XFER = 4'h4,
    DAT_FIN  = 4'h8
  } sdh_dat_st_t;
endpackage : sdh_pkg

// File: rtl/sdh_regs.svh
// Register offsets, field positions, reset values and counts
// Summary of operation
// [R1] Command and data logic held in reset while their reset bits are set.
// [R2] Host sets resets, configures, clears resets, then enables card clock.
// [R3] Memory clock is function clock divided by 2 times divider plus one.
// [R4] Clock runs continuously when enabled, otherwise only during operations.
// [R5] Host keeps memory clock at 400 kHz or lower during card setup.
// [R6] Bus width bit selects 1-bit data bus at zero, 4-bit at one.
// [R7] Each mask bit gates its status flag onto the interrupt request.
// [R8] Response wait is endless at zero, else times out after programmed cycles.
// [R9] Read data wait is endless at zero, else times out after programmed cycles.
// [R10] Host programs a nonzero block length before any transfer.
// [R11] Block count zero runs until stop; otherwise exactly that many blocks.
// [R12] Receive-ready sets when FIFO exceeds threshold; receive read clears it.
// [R13] Transmit-ready sets when FIFO content falls below threshold.
// [R14] Separate CRC error flags for response, read data and write data.
// [R15] Response-done sets on response, or after sending a no-response command. Code leaves it clear on a response with CRC error.
// [R16] Busy-done sets when card no longer busy while busy is expected.
// [R17] Card-busy status bit follows busy signal, complement of busy-done.
// [R18] Data-done sets after all bytes moved and CRC and programming finish.
// [R19] Transfer-done sets when final byte moves to the shift register.
// [R20] Host enables transfer-done on multi-block writes and then sends stop.
// [R21] All enabled flags combine into one interrupt request output.
// [R22] Reading the primary status register clears all its flags.
`ifndef SDH_REGS_SVH
`define SDH_REGS_SVH
`define SDH_OFS_CTL     6'h00
`define SDH_OFS_CLK     6'h04
`define SDH_OFS_ST0     6'h08
`define SDH_OFS_ST1     6'h0C
`define SDH_OFS_IM      6'h10
`define SDH_OFS_TOR     6'h14
`define SDH_OFS_TOD     6'h18
`define SDH_OFS_BLEN    6'h1C
`define SDH_OFS_NBLK    6'h20
`define SDH_OFS_NBLC    6'h24
`define SDH_OFS_DRR     6'h28
`define SDH_OFS_CMD     6'h2C
`define SDH_OFS_FIFO    6'h30
`define SDH_CTL_DRST    0
`define SDH_CTL_CRST    1
`define SDH_CTL_WIDTH   2
`define SDH_CLK_EN      8
`define SDH_CMD_RSP     0
`define SDH_CMD_BSY     1
`define SDH_CMD_DAT     2
`define SDH_CMD_WR      3
`define SDH_ST_DATDN    0
`define SDH_ST_BSYDN    1
`define SDH_ST_RSPDN    2
`define SDH_ST_TORD     3
`define SDH_ST_TORS     4
`define SDH_ST_WRITE_CRC_ERROR_FLAG    5
`define SDH_ST_READ_CRC_ERROR_FLAG    6
`define SDH_ST_RESPONSE_CRC_ERROR_FLAG    7
`define SDH_ST_TXRDY    9
`define SDH_ST_RXRDY    10
`define SDH_ST_TRNDN    12
`define SDH_CTL_RST     3'h3
`define SDH_DIV_RST     8'hFF
`define SDH_BLEN_RST    12'h200
`define SDH_BSY_SETTLE  8'h02
`endif

// File: test/sdh_card_model.sv
// Card side model: command sent, response and busy level
`timescale 1ns/10ps
module sdh_card_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cmd_start,
  input  wire logic [1:0] i_rsp_mode,
  input  wire logic [7:0] i_busy_len,
  output logic            o_cmd_sent,
  output logic            o_rsp_rcvd,
  output logic            o_rsp_crc_err,
  output logic            o_card_busy
);
  logic [3:0] cnt_r;
  logic [7:0] bsy_r;
  logic       act_r;
  assign o_card_busy = bsy_r != 8'h0;
  // Mode 0 answers, 1 stays silent, 2 answers with bad CRC
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r         <= 4'h0;
      bsy_r         <= 8'h0;
      act_r         <= 1'b0;
      o_cmd_sent    <= 1'b0;
      o_rsp_rcvd    <= 1'b0;
      o_rsp_crc_err <= 1'b0;
    end else begin
      o_cmd_sent    <= 1'b0;
      o_rsp_rcvd    <= 1'b0;
      o_rsp_crc_err <= 1'b0;
      if (bsy_r != 8'h0) begin
        bsy_r <= bsy_r - 8'h1;
      end
      if (i_cmd_start) begin
        act_r <= 1'b1;
        cnt_r <= 4'h0;
      end else if (act_r) begin
        cnt_r      <= cnt_r + 4'h1;
        o_cmd_sent <= cnt_r == 4'h2;
        if (cnt_r == 4'h8) begin
          act_r <= 1'b0;
          if (i_rsp_mode != 2'd1) begin
            o_rsp_rcvd    <= 1'b1;
            o_rsp_crc_err <= i_rsp_mode == 2'd2;
            bsy_r         <= i_busy_len;
          end
        end
      end
    end
  end
endmodule : sdh_card_model

// File: test/sdh_cs_properties.sv
// Assertion checker for the card host configuration and status block
`timescale 1ns/10ps
`include "sdh_regs.svh"
module sdh_cs_properties (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [5:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_card_clk,
  input wire logic        o_cmd_logic_rst,
  input wire logic        o_data_logic_rst,
  input wire logic        o_bus_4bit,
  input wire logic        o_cmd_start,
  input wire logic        o_irq
);
  logic [7:0]  div_r;
  logic        en_r;
  logic        clean_r;
  logic        clk_q_r;
  logic [8:0]  run_r;
  logic [12:0] im_r;
  logic        wr_ctl;
  logic        edge_seen;
  assign wr_ctl = i_wr && (i_addr == `SDH_OFS_CTL);
  assign edge_seen = o_card_clk != clk_q_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Shadow of clock and mask settings, phase length counter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r   <= 8'hFF;
      en_r    <= 1'b0;
      im_r    <= 13'h0;
      clean_r <= 1'b0;
      clk_q_r <= 1'b0;
      run_r   <= 9'h0;
    end else begin
      clk_q_r <= o_card_clk;
      run_r   <= edge_seen ? 9'h1 : run_r + {8'h0, run_r != 9'h1FF};
      if (i_wr && i_addr == `SDH_OFS_CLK) begin
        div_r   <= i_wdata[7:0];
        en_r    <= i_wdata[8];
        clean_r <= 1'b0;
      end else if (edge_seen) begin
        clean_r <= 1'b1;
      end
      if (i_wr && i_addr == `SDH_OFS_IM) begin
        im_r <= i_wdata[12:0];
      end
    end
  end
  property p_cmd_held; o_cmd_logic_rst |-> !o_cmd_start; endproperty
  a_cmd_held: assert property (p_cmd_held)
    else $error("command start while command logic held");
  property p_rst_src;
    $changed({o_cmd_logic_rst, o_data_logic_rst})
      |-> $past(wr_ctl) || $past(wr_ctl, 2);
  endproperty
  a_rst_src: assert property (p_rst_src)
    else $error("logic reset output moved without control write");
  property p_width;
    $changed(o_bus_4bit) |-> o_bus_4bit ==
      ($past(wr_ctl) ? $past(i_wdata[2]) : $past(i_wdata[2], 2));
  endproperty
  a_width: assert property (p_width)
    else $error("bus width output differs from written bit");
  property p_clk_period;
    edge_seen && clean_r && en_r |-> run_r == {1'b0, div_r} + 9'h1;
  endproperty
  a_clk_period: assert property (p_clk_period)
    else $error("card clock phase length wrong");
  property p_irq_mask;
    im_r == 13'h0 && $past(im_r) == 13'h0 |-> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised with all mask bits clear");
  property p_rdata_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read cycle");
  property p_start_src;
    o_cmd_start |-> $past(i_wr && i_addr == `SDH_OFS_CMD);
  endproperty
  a_start_src: assert property (p_start_src)
    else $error("command start without command write");
  property p_start_pulse;
    o_cmd_start && !(i_wr && i_addr == `SDH_OFS_CMD) |=> !o_cmd_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("command start longer than one cycle");
endmodule : sdh_cs_properties

bind sdh_config_status sdh_cs_properties u_sdh_cs_properties (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_card_clk(o_card_clk),
  .o_cmd_logic_rst(o_cmd_logic_rst), .o_data_logic_rst(o_data_logic_rst),
  .o_bus_4bit(o_bus_4bit), .o_cmd_start(o_cmd_start), .o_irq(o_irq));

// File: test/testbench.sv
// Testbench for the card host configuration and status block
`timescale 1ns/10ps
`include "sdh_regs.svh"
module testbench;
  logic        i_clk, i_rst_n, i_wr, i_rd;
  logic [5:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rx_word;
  logic [7:0]  level, busy_len;
  logic [4:0]  pls;
  logic [1:0]  rsp_mode;
  logic        cmd_sent, rsp_rcvd, rsp_crc, card_busy, o_card_clk;
  logic        o_cmd_logic_rst, o_data_logic_rst, o_bus_4bit;
  logic        o_cmd_start, o_irq;
  int          mismatches;
  int          checks_done;
  sdh_config_status u_sdh_config_status (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_data(rx_word),
    .i_fifo_level(level), .i_cmd_sent(cmd_sent), .i_rsp_rcvd(rsp_rcvd),
    .i_rsp_crc_err(rsp_crc), .i_rd_crc_err(pls[0]), .i_wr_crc_err(pls[1]),
    .i_byte_moved(pls[2]), .i_stop_sent(pls[3]), .i_data_complete(pls[4]),
    .i_card_busy(card_busy), .o_card_clk(o_card_clk),
    .o_cmd_logic_rst(o_cmd_logic_rst), .o_data_logic_rst(o_data_logic_rst),
    .o_bus_4bit(o_bus_4bit), .o_cmd_start(o_cmd_start), .o_irq(o_irq));
  sdh_card_model u_sdh_card_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_start(o_cmd_start),
    .i_rsp_mode(rsp_mode), .i_busy_len(busy_len), .o_cmd_sent(cmd_sent),
    .o_rsp_rcvd(rsp_rcvd), .o_rsp_crc_err(rsp_crc), .o_card_busy(card_busy));
  always #20 i_clk = ~i_clk;
  task automatic chk(input string n, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input string n, input logic [5:0] a,
                     input logic [31:0] m, e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(n, o_rdata & m, e);
  endtask : rdc
  task automatic pul(input int k);
    @(posedge i_clk);
    pls[k] <= 1'b1;
    @(posedge i_clk);
    pls[k] <= 1'b0;
  endtask : pul
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    tick(6000);
    mismatches++;
    stop_test();
  end
  initial begin
    {i_clk, i_rst_n, i_wr, i_rd, i_addr, i_wdata, pls, rsp_mode} = '0;
    {rx_word, level, busy_len} = {32'hA5C3_0F96, 8'h10, 8'h0};
    tick(6);
    i_rst_n <= 1'b1;
    tick(3);
    rdc("ctl_rst", `SDH_OFS_CTL, 32'hFFFFFFFF, 32'h3);
    chk("held", {o_cmd_logic_rst, o_data_logic_rst}, 32'h3);
    chk("clk_idle", o_card_clk, 32'h0);
    rdc("clk_stop", `SDH_OFS_ST1, 32'h2, 32'h2);
    rdc("clk_rst", `SDH_OFS_CLK, 32'hFFFFFFFF, 32'hFF);
    rdc("blen_rst", `SDH_OFS_BLEN, 32'hFFFFFFFF, 32'h200);
    rdc("unmapped", 6'h3C, 32'hFFFFFFFF, 32'h0);
    wr(`SDH_OFS_CTL, 32'h7);
    wr(`SDH_OFS_CLK, 32'h1F);
    wr(`SDH_OFS_TOR, 32'hFF);
    wr(`SDH_OFS_TOD, 32'h3);
    wr(`SDH_OFS_BLEN, 32'h4);
    wr(`SDH_OFS_NBLK, 32'h2);
    wr(`SDH_OFS_FIFO, 32'h8);
    wr(`SDH_OFS_IM, 32'h0);
    wr(`SDH_OFS_CTL, 32'h4);
    wr(`SDH_OFS_CLK, 32'h11F);
    chk("width", o_bus_4bit, 32'h1);
    tick(150);
    wr(`SDH_OFS_CMD, 32'h0);
    tick(20);
    rdc("rsp_done", `SDH_OFS_ST0, 32'h4, 32'h4);
    wr(`SDH_OFS_CLK, 32'h101);
    @(posedge i_clk) rsp_mode <= 2'd1;
    wr(`SDH_OFS_CMD, 32'h1);
    tick(1000);
    rdc("tor_early", `SDH_OFS_ST0, 32'h14, 32'h0);
    tick(60);
    rdc("tor_flag", `SDH_OFS_ST0, 32'h14, 32'h10);
    rdc("st0_clr", `SDH_OFS_ST0, 32'h10, 32'h0);
    wr(`SDH_OFS_TOR, 32'h0);
    wr(`SDH_OFS_CMD, 32'h1);
    tick(1100);
    rdc("tor_zero", `SDH_OFS_ST0, 32'h10, 32'h0);
    wr(`SDH_OFS_CTL, 32'h6);
    wr(`SDH_OFS_CMD, 32'h0);
    rdc("cmd_kept", `SDH_OFS_CMD, 32'hF, 32'h1);
    wr(`SDH_OFS_CTL, 32'h4);
    @(posedge i_clk) rsp_mode <= 2'd2;
    wr(`SDH_OFS_CMD, 32'h1);
    tick(20);
    rdc("rsp_crc", `SDH_OFS_ST0, 32'h84, 32'h80);
    rsp_mode <= 2'd0;
    busy_len <= 8'd40;
    wr(`SDH_OFS_CMD, 32'h3);
    tick(20);
    rdc("busy_on", `SDH_OFS_ST1, 32'h1, 32'h1);
    rdc("busy_wait", `SDH_OFS_ST0, 32'h6, 32'h4);
    tick(60);
    rdc("busy_done", `SDH_OFS_ST0, 32'h6, 32'h2);
    rdc("busy_off", `SDH_OFS_ST1, 32'h3, 32'h0);
    wr(`SDH_OFS_IM, 32'h4);
    wr(`SDH_OFS_CMD, 32'h0);
    tick(15);
    chk("irq_on", o_irq, 32'h1);
    wr(`SDH_OFS_IM, 32'h0);
    tick(2);
    chk("irq_off", o_irq, 32'h0);
    rdc("flag_kept", `SDH_OFS_ST0, 32'h4, 32'h4);
    pul(0);
    pul(1);
    rdc("data_crc", `SDH_OFS_ST0, 32'h60, 32'h60);
    wr(`SDH_OFS_CMD, 32'h4);
    tick(60);
    rdc("tod_flag", `SDH_OFS_ST0, 32'h8, 32'h8);
    wr(`SDH_OFS_IM, 32'h1000);
    wr(`SDH_OFS_CMD, 32'hC);
    tick(10);
    repeat (7) pul(2);
    rdc("trn_early", `SDH_OFS_ST0, 32'h1000, 32'h0);
    rdc("blk_left", `SDH_OFS_NBLC, 32'hFFFF, 32'h1);
    pul(2);
    tick(2);
    chk("trn_irq", o_irq, 32'h1);
    rdc("trn_done", `SDH_OFS_ST0, 32'h1001, 32'h1000);
    pul(3);
    pul(4);
    rdc("dat_done", `SDH_OFS_ST0, 32'h1, 32'h1);
    wr(`SDH_OFS_NBLK, 32'h0);
    wr(`SDH_OFS_CMD, 32'hC);
    tick(10);
    repeat (12) pul(2);
    rdc("open_run", `SDH_OFS_ST0, 32'h1001, 32'h0);
    pul(3);
    pul(4);
    rdc("stop_end", `SDH_OFS_ST0, 32'h1, 32'h1);
    @(posedge i_clk) level <= 8'h04;
    tick(3);
    @(posedge i_clk) level <= 8'h09;
    tick(3);
    rdc("fifo_rdy", `SDH_OFS_ST0, 32'h600, 32'h600);
    @(posedge i_clk) level <= 8'h04;
    tick(3);
    @(posedge i_clk) level <= 8'h09;
    tick(3);
    rdc("rx_word", `SDH_OFS_DRR, 32'hFFFFFFFF, rx_word);
    rdc("rx_clr", `SDH_OFS_ST0, 32'h400, 32'h0);
    stop_test();
  end
endmodule : testbench
